// ---- rtl/transparent_serial_channel.sv ----
// transparent serial channel: descriptor-driven bit-stream framer with wishbone registers
//
// Chosen here: the Wishbone interface to the registers and the register offsets.
`default_nettype none
module transparent_serial_channel (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  input wire logic link_clk,
  input wire logic rx_data,
  input wire logic carrier_detect_n,
  input wire logic clear_to_send_n,
  input wire logic slot_active,
  output logic tx_data,
  output logic rts_n
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [3:0] ctrl;
    logic [2:0] evt;
    logic [2:0] mask;
    logic tx_ready;
    logic tx_last;
    logic tx_irq;
    logic [5:0] tx_len;
    logic [5:0] tx_addr;
    logic [1:0] rx_empty;
    logic [5:0] rx_addr0;
    logic [5:0] rx_addr1;
    logic [5:0] max_len;
    tsc_pkg::tx_state_type tx_state;
    logic [5:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_byte;
    logic [15:0] tx_word;
    logic tx_wvalid;
    logic tx_out;
    logic rts_n;
    tsc_pkg::rx_state_type rx_state;
    logic [15:0] rx_sh;
    logic [3:0] rx_bit;
    logic rx_idx;
    logic [5:0] rx_off;
    logic [2:0] lk;
    logic [1:0] rxd;
    logic [1:0] cd;
    logic [1:0] cts;
    logic [1:0] slot;
  } state_type;

  state_type s;
  state_type n;
  logic [15:0] mem [0:tsc_pkg::MEM_WORDS-1];
  logic mem_we;
  logic [4:0] mem_a;
  logic [15:0] mem_d;
  logic bit_edge;
  logic rx_tick;
  logic req;
  logic wr;
  logic tx_start;
  logic tx_load;
  logic tx_finish;
  logic rx_store;
  logic resync;
  logic [2:0] ev_set;
  logic [2:0] ev_clr;
  logic [5:0] la;
  logic [5:0] cnt_inc;
  logic [5:0] off_inc;
  logic [5:0] rx_a;
  logic [15:0] word16;
  logic [7:0] byte8;
  logic [15:0] rx_word;
  logic [31:0] cur;
  logic [31:0] w;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] rev8(input logic [7:0] b);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = b[7-i];
    end
    return r;
  endfunction : rev8

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n = s;
    mem_we = 1'b0;
    mem_a = '0;
    mem_d = '0;
    tx_start = 1'b0;
    tx_load = 1'b0;
    tx_finish = 1'b0;
    rx_store = 1'b0;
    ev_set = '0;
    ev_clr = '0;
    n.lk = {s.lk[1:0], link_clk};
    n.rxd = {s.rxd[0], rx_data};
    n.cd = {s.cd[0], carrier_detect_n};
    n.cts = {s.cts[0], clear_to_send_n};
    n.slot = {s.slot[0], slot_active};
    bit_edge = s.lk[1] & ~s.lk[2];
    rx_tick = bit_edge & (~s.ctrl[tsc_pkg::CTRL_PCM] | s.slot[1]);
    req = wb_cyc_i & wb_stb_i & ~s.ack;
    resync = 1'b0;
    cnt_inc = s.tx_cnt + 6'h01;
    off_inc = s.rx_off + tsc_pkg::WORD_BYTES;
    rx_a = (s.rx_idx ? s.rx_addr1 : s.rx_addr0) + s.rx_off;
    rx_word = {s.rxd[1], s.rx_sh[15:1]};
    if (s.ctrl[tsc_pkg::CTRL_REV]) begin
      rx_word = {rev8(rx_word[15:8]), rev8(rx_word[7:0])};
    end
    // transmitter
    unique case (s.tx_state)
      tsc_pkg::TX_IDLE: begin
        n.tx_out = 1'b1;
        n.rts_n = 1'b1;
        if (s.ctrl[tsc_pkg::CTRL_TX_EN] & s.tx_ready) begin
          n.tx_state = tsc_pkg::TX_SYNC;
        end
      end
      tsc_pkg::TX_SYNC: begin
        n.rts_n = 1'b0;
        tx_start = bit_edge & ~s.cts[1];
      end
      tsc_pkg::TX_WAIT: begin
        tx_start = s.tx_ready;
      end
      tsc_pkg::TX_SEND: begin
        if (bit_edge) begin
          if (s.tx_cnt == s.tx_len) begin
            tx_finish = 1'b1;
          end else begin
            n.tx_out = s.tx_byte[0];
            n.tx_byte = {1'b1, s.tx_byte[7:1]};
            n.tx_bit = s.tx_bit + 3'h1;
            if (s.tx_bit == tsc_pkg::LAST_BYTE_BIT) begin
              n.tx_cnt = cnt_inc;
              tx_load = cnt_inc != s.tx_len;
            end
          end
        end
      end
    endcase
    if (tx_start) begin
      n.tx_cnt = '0;
      n.tx_wvalid = 1'b0;
      tx_finish = s.tx_len == '0;
    end
    la = tx_start ? s.tx_addr : s.tx_addr + cnt_inc;
    word16 = (la[0] & s.tx_wvalid & ~tx_start) ? s.tx_word : mem[la[5:1]];
    byte8 = la[0] ? word16[15:8] : word16[7:0];
    if ((tx_start & ~tx_finish) | tx_load) begin
      n.tx_word = word16;
      n.tx_wvalid = 1'b1;
      n.tx_byte = s.ctrl[tsc_pkg::CTRL_REV] ? rev8(byte8) : byte8;
      n.tx_bit = '0;
      n.tx_state = tsc_pkg::TX_SEND;
    end
    if (tx_finish) begin
      n.tx_ready = 1'b0;
      n.rts_n = s.rts_n | s.tx_last;
      n.tx_out = 1'b1;
      ev_set[tsc_pkg::EV_TX_DONE] = s.tx_irq;
      n.tx_state = s.tx_last ? tsc_pkg::TX_IDLE : tsc_pkg::TX_WAIT;
    end
    if (~s.ctrl[tsc_pkg::CTRL_TX_EN]) begin
      n.tx_state = tsc_pkg::TX_IDLE;
      n.rts_n = 1'b1;
    end
    // receiver
    unique case (s.rx_state)
      tsc_pkg::RX_HUNT: begin
        if (s.ctrl[tsc_pkg::CTRL_RX_EN] & ~s.cd[1] & bit_edge) begin
          n.rx_state = tsc_pkg::RX_RECV;
          n.rx_bit = '0;
        end
      end
      tsc_pkg::RX_RECV: begin
        if (rx_tick) begin
          n.rx_sh = {s.rxd[1], s.rx_sh[15:1]};
          n.rx_bit = s.rx_bit + 4'h1;
          if (s.rx_bit == tsc_pkg::LAST_WORD_BIT) begin
            if (s.rx_empty[s.rx_idx]) begin
              rx_store = 1'b1;
            end else begin
              ev_set[tsc_pkg::EV_NO_BUF] = 1'b1;
              n.rx_state = tsc_pkg::RX_BUSY;
            end
          end
        end
        if (s.cd[1]) begin
          n.rx_state = tsc_pkg::RX_HUNT;
        end
      end
      tsc_pkg::RX_BUSY: begin
        n.rx_state = tsc_pkg::RX_BUSY;
      end
      default: begin
        n.rx_state = tsc_pkg::RX_HUNT;
      end
    endcase
    if (rx_store) begin
      mem_we = 1'b1;
      mem_a = rx_a[5:1];
      mem_d = rx_word;
      ev_set[tsc_pkg::EV_RX_WORD] = 1'b1;
      n.rx_off = off_inc;
      if (off_inc >= s.max_len) begin
        n.rx_empty[s.rx_idx] = 1'b0;
        n.rx_idx = ~s.rx_idx;
        n.rx_off = '0;
      end
    end
    // register bus
    n.ack = req & ~(rx_store & wb_adr_i[tsc_pkg::MEM_SEL_BIT]);
    wr = n.ack & wb_we_i;
    cur = '0;
    if (wb_adr_i[tsc_pkg::MEM_SEL_BIT]) begin
      cur = {16'h0000, mem[wb_adr_i[6:2]]};
    end else begin
      case (wb_adr_i)
        tsc_pkg::CTRL_OFS: cur = {28'h000_0000, s.ctrl};
        tsc_pkg::EVENT_OFS: cur = {29'h0000_0000, s.evt};
        tsc_pkg::MASK_OFS: cur = {29'h0000_0000, s.mask};
        tsc_pkg::STATUS_OFS: cur = {26'h000_0000, s.rts_n, s.rx_idx, s.rx_state, s.tx_state};
        tsc_pkg::TX_DESC_OFS: cur = {s.tx_ready, s.tx_last, s.tx_irq, 7'h00, s.tx_len, 10'h000, s.tx_addr};
        tsc_pkg::RX_DESC0_OFS: cur = {s.rx_empty[0], 25'h000_0000, s.rx_addr0};
        tsc_pkg::RX_DESC1_OFS: cur = {s.rx_empty[1], 25'h000_0000, s.rx_addr1};
        tsc_pkg::MAX_LEN_OFS: cur = {26'h000_0000, s.max_len};
        default: cur = '0;
      endcase
    end
    w = merge(cur, wb_dat_i, wb_sel_i);
    n.rdata = n.ack ? cur : '0;
    if (wr & wb_adr_i[tsc_pkg::MEM_SEL_BIT]) begin
      mem_we = 1'b1;
      mem_a = wb_adr_i[6:2];
      mem_d = w[15:0];
    end else if (wr) begin
      case (wb_adr_i)
        tsc_pkg::CTRL_OFS: begin
          n.ctrl = w[3:0];
          resync = wb_sel_i[0] & wb_dat_i[tsc_pkg::CTRL_RESYNC];
        end
        tsc_pkg::EVENT_OFS: ev_clr = wb_dat_i[2:0] & {3{wb_sel_i[0]}};
        tsc_pkg::MASK_OFS: n.mask = w[2:0];
        tsc_pkg::TX_DESC_OFS: begin
          n.tx_ready = w[tsc_pkg::DESC_READY];
          n.tx_last = w[tsc_pkg::DESC_LAST];
          n.tx_irq = w[tsc_pkg::DESC_IRQ];
          n.tx_len = w[tsc_pkg::DESC_LEN +: 6];
          n.tx_addr = w[tsc_pkg::DESC_ADDR +: 6];
        end
        tsc_pkg::RX_DESC0_OFS: begin
          n.rx_empty[0] = w[tsc_pkg::DESC_READY];
          n.rx_addr0 = w[tsc_pkg::DESC_ADDR +: 6];
        end
        tsc_pkg::RX_DESC1_OFS: begin
          n.rx_empty[1] = w[tsc_pkg::DESC_READY];
          n.rx_addr1 = w[tsc_pkg::DESC_ADDR +: 6];
        end
        tsc_pkg::MAX_LEN_OFS: n.max_len = w[5:0];
        default: n.max_len = s.max_len;
      endcase
    end
    if (resync | ~s.ctrl[tsc_pkg::CTRL_RX_EN]) begin
      n.rx_state = tsc_pkg::RX_HUNT;
    end
    n.evt = (s.evt & ~ev_clr) | ev_set;
  end

  // ----------------------------------------
  // registers and buffer memory
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s <= '0;
      s.ctrl <= tsc_pkg::CTRL_RST;
      s.evt <= tsc_pkg::EVENT_RST;
      s.mask <= tsc_pkg::MASK_RST;
      s.max_len <= tsc_pkg::MAX_LEN_RST;
      s.tx_out <= 1'b1;
      s.rts_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[mem_a] <= mem_d;
    end
  end

  assign wb_dat_o = s.rdata;
  assign wb_ack_o = s.ack;
  assign irq = |(s.evt & s.mask);
  assign tx_data = s.tx_out;
  assign rts_n = s.rts_n;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  idle_ones_a: assert property ((s.tx_state == tsc_pkg::TX_IDLE)
    && $past(s.tx_state == tsc_pkg::TX_IDLE) |-> s.tx_out)
    else $error("line not idling high");
  last_idle_a: assert property (tx_finish && s.tx_last && s.ctrl[0] |=> s.tx_state == tsc_pkg::TX_IDLE)
    else $error("last buffer did not end frame");
  idle_rts_a: assert property (s.tx_state == tsc_pkg::TX_IDLE |-> s.rts_n)
    else $error("rts active during idle");
  sync_gate_a: assert property (s.tx_state == tsc_pkg::TX_SYNC && !(bit_edge && !s.cts[1])
    |=> s.tx_state != tsc_pkg::TX_SEND)
    else $error("send began without sync");
  tx_done_a: assert property (tx_finish && s.tx_irq |=> s.evt[0])
    else $error("transmit done event missing");
  hunt_quiet_a: assert property (s.rx_state != tsc_pkg::RX_RECV |-> !rx_store)
    else $error("data stored before sync");
  word_edge_a: assert property (rx_store |-> rx_tick && s.rx_bit == 4'hf)
    else $error("word stored before sixteen clocks");
  rx_word_a: assert property (rx_store |=> s.evt[1] && $past(mem_we))
    else $error("receive word event missing");
  buf_adv_a: assert property (rx_store && (off_inc >= s.max_len)
    |=> s.rx_off == 6'h00 && s.rx_idx != $past(s.rx_idx))
    else $error("full buffer did not advance");
  no_buf_a: assert property (s.rx_state == tsc_pkg::RX_RECV
    ##1 s.rx_state == tsc_pkg::RX_BUSY |-> s.evt[2])
    else $error("no buffer event missing");
  cd_loss_a: assert property (s.rx_state == tsc_pkg::RX_RECV && s.cd[1] |=> s.rx_state == tsc_pkg::RX_HUNT)
    else $error("carrier loss not handled");

  word_store_c: cover property (rx_store ##[1:300] rx_store);
  frame_end_c: cover property (tx_finish && s.tx_last);
  rx_busy_c: cover property (s.rx_state == tsc_pkg::RX_BUSY);
  irq_c: cover property (irq);
endmodule : transparent_serial_channel
`default_nettype wire

// ---- pkg/tsc_pkg.sv ----
// package: register map, field positions, reset values and states of the transparent channel
`default_nettype none
package tsc_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] EVENT_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] TX_DESC_OFS = 8'h10;
  localparam logic [7:0] RX_DESC0_OFS = 8'h14;
  localparam logic [7:0] RX_DESC1_OFS = 8'h18;
  localparam logic [7:0] MAX_LEN_OFS = 8'h1c;
  localparam int MEM_SEL_BIT = 7;
  localparam int MEM_WORDS = 32;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_RX_EN = 1;
  localparam int CTRL_REV = 2;
  localparam int CTRL_PCM = 3;
  localparam int CTRL_RESYNC = 4;
  localparam int EV_TX_DONE = 0;
  localparam int EV_RX_WORD = 1;
  localparam int EV_NO_BUF = 2;
  localparam int DESC_READY = 31;
  localparam int DESC_LAST = 30;
  localparam int DESC_IRQ = 29;
  localparam int DESC_LEN = 16;
  localparam int DESC_ADDR = 0;
  // ----------------------------------------
  // reset values and counts
  // ----------------------------------------
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [2:0] EVENT_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic [5:0] MAX_LEN_RST = 6'h02;
  localparam logic [2:0] LAST_BYTE_BIT = 3'h7;
  localparam logic [3:0] LAST_WORD_BIT = 4'hf;
  localparam logic [5:0] WORD_BYTES = 6'h02;
  // ----------------------------------------
  // states
  // ----------------------------------------
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SYNC = 2'b01,
    TX_SEND = 2'b11,
    TX_WAIT = 2'b10
  } tx_state_type;
  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_RECV = 2'b01,
    RX_BUSY = 2'b11
  } rx_state_type;
endpackage : tsc_pkg
`default_nettype wire

// ---- verification/serial_line_model.sv ----
// serial line partner: link clock, receive bits, carrier, clear to send, slot timing, transmit capture
`default_nettype none
module serial_line_model (
  input wire logic run,
  input wire logic carrier_on,
  input wire logic cts_on,
  input wire logic slot_mode,
  input wire logic tx_data,
  input wire logic rts_n,
  output logic link_clk,
  output logic rx_data,
  output logic carrier_detect_n,
  output logic clear_to_send_n,
  output logic slot_active
);
  timeunit 1ns;
  timeprecision 1ns;
  bit rx_q[$];
  bit cap_q[$];
  int sent = 0;
  int slot_cnt = 0;
  initial begin
    link_clk = 1'b0;
    rx_data = 1'b1;
    carrier_detect_n = 1'b1;
    slot_active = 1'b0;
  end
  assign clear_to_send_n = !cts_on;
  // ----------------------------------------
  // line timing: clock stands still unless run
  // ----------------------------------------
  always #400 link_clk = run ? !link_clk : 1'b0;
  always @(negedge link_clk) begin
    slot_cnt = (slot_cnt + 1) % 10;
    slot_active <= slot_mode && slot_cnt < 7;
    if (!rts_n) begin
      cap_q.push_back(tx_data);
    end
    if (carrier_detect_n || rx_q.size() == 0 || (slot_mode && slot_cnt >= 7)) begin
      rx_data <= !rx_data;
    end else begin
      rx_data <= rx_q.pop_front();
      sent++;
    end
    carrier_detect_n <= !carrier_on;
  end
endmodule : serial_line_model
`default_nettype wire

// ---- verification/transparent_serial_channel_bench.sv ----
// self-checking bench: wishbone tasks, line partner and directed checks against expected values worked out from seeded random data
`default_nettype none
module transparent_serial_channel_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, irq, link_clk, rx_data, carrier_detect_n, clear_to_send_n, slot_active, tx_data, rts_n;
  logic run = 1'b0;
  logic carrier_on = 1'b0;
  logic cts_on = 1'b0;
  logic slot_mode = 1'b0;
  int fail_count = 0;
  int check_count = 0;
  always #50 ref_clk = !ref_clk;
  transparent_serial_channel u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .link_clk(link_clk), .rx_data(rx_data),
    .carrier_detect_n(carrier_detect_n), .clear_to_send_n(clear_to_send_n), .slot_active(slot_active),
    .tx_data(tx_data), .rts_n(rts_n));
  serial_line_model u_line (.run(run), .carrier_on(carrier_on), .cts_on(cts_on), .slot_mode(slot_mode),
    .tx_data(tx_data), .rts_n(rts_n), .link_clk(link_clk), .rx_data(rx_data),
    .carrier_detect_n(carrier_detect_n), .clear_to_send_n(clear_to_send_n), .slot_active(slot_active));
  // ----------------------------------------
  // bus, wait and compare tasks
  // ----------------------------------------
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rdat);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge ref_clk);
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] s;
    wb(1'b1, adr, dat, s);
  endtask : wr
  task automatic rd(input logic [7:0] adr, output logic [31:0] q);
    wb(1'b0, adr, 32'h0000_0000, q);
  endtask : rd
  task automatic link_wait(input int n);
    repeat (n) @(posedge link_clk);
    repeat (10) @(posedge ref_clk);
  endtask : link_wait
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    #1_000_000;
    fail_count++;
    tally_and_finish();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] q, got_v, exp_v;
    logic [7:0] tx_b[3];
    logic [15:0] w[5];
    int i, j;
    void'($urandom(79));
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    run <= 1'b1;
    rd(tsc_pkg::MAX_LEN_OFS, q);
    chk(q, 32'h0000_0002);
    rd(8'h20, q);
    chk(q, 32'h0000_0000);
    for (i = 0; i < 2; i++) begin
      cts_on <= 1'b0;
      for (j = 0; j < 3; j++) tx_b[j] = 8'($urandom());
      if (i == 0) tx_b[0][0] = 1'b0;
      else tx_b[0][7] = 1'b0;
      wr(8'hc0, {16'h0000, tx_b[0], 8'h00});
      wr(8'hc4, {16'h0000, tx_b[2], tx_b[1]});
      wr(tsc_pkg::MASK_OFS, 32'h0000_0000);
      wr(tsc_pkg::CTRL_OFS, 32'(1 + 4 * i));
      wr(tsc_pkg::TX_DESC_OFS, 32'he003_0021);
      link_wait(6);
      rd(tsc_pkg::STATUS_OFS, q);
      chk(q & 32'h0000_0003, 32'h0000_0001);
      u_line.cap_q.delete();
      cts_on <= 1'b1;
      j = 0;
      do begin
        rd(tsc_pkg::EVENT_OFS, q);
        j++;
      end while (q[0] !== 1'b1 && j < 400);
      chk(q & 32'h0000_0001, 32'h0000_0001);
      chk(32'(irq), 32'h0000_0000);
      wr(tsc_pkg::MASK_OFS, 32'h0000_0001);
      chk(32'(irq), 32'h0000_0001);
      wr(tsc_pkg::EVENT_OFS, 32'h0000_0001);
      chk(32'(irq), 32'h0000_0000);
      while (u_line.cap_q.size() > 0 && u_line.cap_q[0] == 1'b1) void'(u_line.cap_q.pop_front());
      got_v = 'x;
      exp_v = 32'h0000_0000;
      for (j = 0; j < 24; j++) begin
        exp_v[j] = tx_b[j / 8][(i == 0) ? (j % 8) : (7 - j % 8)];
        if (j < u_line.cap_q.size()) got_v[j] = u_line.cap_q[j];
      end
      chk(got_v & 32'h00ff_ffff, exp_v);
      for (j = 0; j < 8; j++) begin
        link_wait(1);
        chk({30'h0, rts_n, tx_data}, 32'h0000_0003);
      end
    end
    wr(tsc_pkg::MAX_LEN_OFS, 32'h0000_0004);
    wr(tsc_pkg::RX_DESC0_OFS, 32'h8000_0000);
    wr(tsc_pkg::RX_DESC1_OFS, 32'h8000_0010);
    wr(tsc_pkg::MASK_OFS, 32'h0000_0006);
    wr(tsc_pkg::CTRL_OFS, 32'h0000_0002);
    link_wait(20);
    rd(tsc_pkg::EVENT_OFS, q);
    chk(q & 32'h0000_0006, 32'h0000_0000);
    for (i = 0; i < 5; i++) begin
      w[i] = 16'($urandom());
      for (j = 0; j < 16; j++) u_line.rx_q.push_back(w[i][j]);
    end
    carrier_on <= 1'b1;
    wait (u_line.sent == 16);
    rd(tsc_pkg::EVENT_OFS, q);
    chk(q & 32'h0000_0002, 32'h0000_0000);
    link_wait(1);
    rd(tsc_pkg::EVENT_OFS, q);
    chk(q & 32'h0000_0002, 32'h0000_0002);
    chk(32'(irq), 32'h0000_0001);
    wait (u_line.sent == 80);
    link_wait(2);
    for (i = 0; i < 4; i++) begin
      rd(8'h80 + 8'((i / 2) * 32 + (i % 2) * 4), q);
      chk(q & 32'h0000_ffff, {16'h0000, w[i]});
    end
    rd(tsc_pkg::EVENT_OFS, q);
    chk(q & 32'h0000_0004, 32'h0000_0004);
    rd(tsc_pkg::STATUS_OFS, q);
    chk(q & 32'h0000_000c, 32'h0000_000c);
    wr(tsc_pkg::CTRL_OFS, 32'h0000_0012);
    link_wait(2);
    rd(tsc_pkg::STATUS_OFS, q);
    chk(q & 32'h0000_0008, 32'h0000_0000);
    carrier_on <= 1'b0;
    link_wait(3);
    rd(tsc_pkg::STATUS_OFS, q);
    chk(q & 32'h0000_000c, 32'h0000_0000);
    wr(tsc_pkg::EVENT_OFS, 32'h0000_0007);
    wr(tsc_pkg::RX_DESC0_OFS, 32'h8000_0000);
    wr(tsc_pkg::RX_DESC1_OFS, 32'h8000_0000);
    wr(tsc_pkg::CTRL_OFS, 32'h0000_000a);
    slot_mode <= 1'b1;
    w[0] = 16'($urandom());
    for (j = 0; j < 16; j++) u_line.rx_q.push_back(w[0][j]);
    carrier_on <= 1'b1;
    wait (u_line.sent == 96);
    link_wait(2);
    rd(8'h80, q);
    chk(q & 32'h0000_ffff, {16'h0000, w[0]});
    tally_and_finish();
  end
endmodule : transparent_serial_channel_bench
`default_nettype wire
